/* File: rtl/gpx_defines.svh */
// Constants for the general-purpose I/O port block.
// Assumes inclusion by bare name from the package; the design modules use its macros without including it.
`ifndef GPX_DEFINES_SVH
`define GPX_DEFINES_SVH

// ****************************************************************
// Structure
// ****************************************************************
`define GPX_NPORT      5
`define GPX_NPIN       8
`define GPX_NSCE       4
`define GPX_NALL       40

// ****************************************************************
// Reset values
// ****************************************************************
`define GPX_RST_BYTE   8'h00
`define GPX_RST_EDGE   5'h00
`define GPX_RST_VEC    5'h00

// ****************************************************************
// Register selector codes on the write and read strobes
// ****************************************************************
`define GPX_KIND_DATA  2'h0
`define GPX_KIND_DIR   2'h1
`define GPX_KIND_OPT   2'h2
`define GPX_KIND_IEN   2'h3

// ****************************************************************
// Edge control bit meaning
// ****************************************************************
`define GPX_EDGE_FALL  1'h0
`define GPX_EDGE_RISE  1'h1

`endif

/* File: rtl/gpx_pkg.sv */
// Types shared by the I/O port modules.
// Assumes gpx_defines.svh is on the include path.
`include "gpx_defines.svh"

package gpx_pkg;
    typedef logic [`GPX_NPIN-1:0]  gpx_byte_t;
    typedef logic [`GPX_NPORT-1:0] gpx_vec_t;
    typedef logic [`GPX_NALL-1:0]  gpx_all_t;
    typedef enum logic [1:0] {
        GPX_K_DATA = `GPX_KIND_DATA,
        GPX_K_DIR  = `GPX_KIND_DIR,
        GPX_K_OPT  = `GPX_KIND_OPT,
        GPX_K_IEN  = `GPX_KIND_IEN
    } gpx_kind_t;
endpackage : gpx_pkg

/* File: rtl/gpx_bank_if.sv */
// Configuration path between the port top and one eight-pin bank.
// Assumes gpx_pkg is compiled first; one instance per bank.
`timescale 1ns/100ps

interface gpx_bank_if;
    import gpx_pkg::*;
    logic      we_data;  // Write strobe, data latch
    logic      we_dir;   // Write strobe, direction bits
    logic      we_opt;   // Write strobe, option bits
    gpx_byte_t wdata;    // Write value
    gpx_byte_t latch;    // Current data latch
    gpx_byte_t dir;      // Current direction bits
    gpx_byte_t opt;      // Current option bits

    modport ctrl (output we_data, we_dir, we_opt, wdata, input latch, dir, opt);
    modport bank (input we_data, we_dir, we_opt, wdata, output latch, dir, opt);
endinterface : gpx_bank_if

/* File: rtl/gpx_bank.sv */
// One eight-pin port: data latch, direction and option bits, pin drive.
// Assumes pins are synchronous to clk and the wire resolves from pin_oe_n.
`timescale 1ns/100ps

module gpx_bank
    import gpx_pkg::*;
(
    input  wire logic      clk,       // Master clock
    input  wire logic      sys_rst,   // Synchronous reset
    gpx_bank_if.bank       cfg,       // Register writes and view
    input  wire gpx_byte_t pin_in,    // Pin levels
    input  wire gpx_byte_t alt_en,    // Alternate output enables
    input  wire gpx_byte_t alt_val,   // Alternate output values
    input  wire logic      sce_own,   // Storage engine owns this port
    input  wire gpx_byte_t sce_out,   // Storage engine pin values
    input  wire gpx_byte_t sce_oe,    // Storage engine drive enables
    output gpx_byte_t      pin_o,     // Pin output value
    output gpx_byte_t      pin_oe_n,  // Pin drive enable, low drives
    output gpx_byte_t      pin_pu_en, // Pull-up enable
    output gpx_byte_t      alt_in     // Level seen by peripheral input
);

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    // Latch takes writes even while input, so output starts at the right level
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg.latch <= `GPX_RST_BYTE;
        end else if (cfg.we_data) begin
            cfg.latch <= cfg.wdata;
        end
    end

    // Direction and option bits
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg.dir <= `GPX_RST_BYTE;
            cfg.opt <= `GPX_RST_BYTE;
        end else begin
            if (cfg.we_dir) cfg.dir <= cfg.wdata;
            if (cfg.we_opt) cfg.opt <= cfg.wdata;
        end
    end

    // ****************************************************************
    // Pin drive, bit n only from bit n of each register
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_o     <= `GPX_RST_BYTE;
            pin_oe_n  <= ~`GPX_RST_BYTE;
            pin_pu_en <= `GPX_RST_BYTE;
            alt_in    <= `GPX_RST_BYTE;
        end else begin
            for (int i = 0; i < `GPX_NPIN; i++) begin
                pin_pu_en[i] <= 1'b0;
                alt_in[i]    <= pin_in[i];
                if (sce_own) begin
                    pin_o[i]    <= sce_out[i];
                    pin_oe_n[i] <= ~sce_oe[i];
                end else if (alt_en[i]) begin
                    pin_o[i]    <= alt_val[i];
                    pin_oe_n[i] <= 1'b0;
                end else if (cfg.dir[i]) begin
                    // Zero pulls low either way; open drain only releases a one
                    pin_o[i]    <= cfg.latch[i];
                    pin_oe_n[i] <= cfg.latch[i] & ~cfg.opt[i];
                    alt_in[i]   <= cfg.latch[i];
                end else begin
                    pin_o[i]     <= cfg.latch[i];
                    pin_oe_n[i]  <= 1'b1;
                    pin_pu_en[i] <= cfg.opt[i];
                    alt_in[i]    <= pin_in[i];
                end
            end
        end
    end

endmodule : gpx_bank

/* File: rtl/gpx_edge.sv */
// Edge detector for one interrupt vector shared by eight pins.
// Assumes arm already combines enable, input direction and ownership.
`timescale 1ns/100ps

module gpx_edge
    import gpx_pkg::*;
(
    input  wire logic      clk,     // Master clock
    input  wire logic      sys_rst, // Synchronous reset
    input  wire gpx_byte_t pin_in,  // Pin levels
    input  wire gpx_byte_t arm,     // Pins allowed to raise events
    input  wire logic      rising,  // Sensitivity of this vector
    output logic           evt      // One-cycle event pulse
);

    gpx_byte_t sync1; // First stage, read only by sync2
    gpx_byte_t sync2; // Settled level
    gpx_byte_t hist;  // Previous settled level

    // ****************************************************************
    // Two-stage synchroniser and history
    // ****************************************************************
    // Extra stage costs latency but keeps one edge to one event
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1 <= `GPX_RST_BYTE;
            sync2 <= `GPX_RST_BYTE;
            hist  <= `GPX_RST_BYTE;
        end else begin
            sync1 <= pin_in;
            sync2 <= sync1;
            hist  <= sync2;
        end
    end

    // Any armed pin on the vector fires the one shared event
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            evt <= 1'b0;
        end else if (rising == `GPX_EDGE_RISE) begin
            evt <= |(arm & sync2 & ~hist);
        end else begin
            evt <= |(arm & ~sync2 & hist);
        end
    end

endmodule : gpx_edge

/* File: rtl/gpx_port.sv */
// Five general-purpose I/O ports with edge-selectable external interrupts.
// Assumes pins and all strobes are synchronous to clk; strobes are one cycle.
//
// Overview of operation
// - Each port has eight pins, each independently input or output.
// - Pin n follows only bit n of latch, direction and option.
// - Direction 0 makes an input; data reads return the pin level.
// - Writing an input pin's data bit updates the latch, not the pin.
// - Option bit picks floating or pull-up for an input.
// - Enable bit lets edges on an input pin raise requests.
// - Each vector has its own falling or rising edge setting.
// - Any enabled pin on a vector sets that vector's single request.
// - Fetching a vector clears its request latch.
// - Changing the edge setting clears all pending requests.
// - Direction 1 makes an output driven from the latch.
// - Reading an output pin returns the latch value.
// - Option bit picks push-pull or open-drain for an output.
// - Zero drives low; one drives high or releases for open drain.
// - Enabled alternate output forces the pin to output, overriding the port.
// - Reading a pin carrying an alternate output returns its state.
// - Floating input routes the pin level to the peripheral input.
// - Storage engine can take over the pins of the first four ports.
// - Output option 0 is open drain, 1 is push-pull.
// - Reset clears data, direction and option: floating inputs.
// - Requests reach the processor only when its mask allows.
`timescale 1ns/100ps

module gpx_port
    import gpx_pkg::*;
(
    input  wire logic      clk,          // 50 MHz master clock
    input  wire logic      sys_rst,      // Synchronous reset, high
    input  wire logic      wr_en,        // Register write strobe
    input  wire logic [2:0] wr_port,     // Port written
    input  wire gpx_kind_t wr_kind,      // Register written
    input  wire gpx_byte_t wr_data,      // Write value
    input  wire logic      edge_wr,      // Edge control write strobe
    input  wire gpx_vec_t  edge_wdata,   // Edge control value, 1 rising
    input  wire logic      rd_en,        // Register read strobe
    input  wire logic [2:0] rd_port,     // Port read
    input  wire gpx_kind_t rd_kind,      // Register read
    input  wire gpx_vec_t  vec_fetch,    // Vector fetch pulses
    input  wire logic      cpu_int_mask, // Processor mask, high blocks
    input  wire gpx_all_t  pin_in,       // Pin levels
    input  wire gpx_all_t  alt_en,       // Alternate output enables
    input  wire gpx_all_t  alt_val,      // Alternate output values
    input  wire logic [`GPX_NSCE-1:0] sce_own, // Storage engine ownership
    input  wire logic [31:0] sce_out,    // Storage engine values
    input  wire logic [31:0] sce_oe,     // Storage engine drive enables
    output gpx_all_t       pin_o,        // Pin output values
    output gpx_all_t       pin_oe_n,     // Drive enables, low drives
    output gpx_all_t       pin_pu_en,    // Pull-up enables
    output gpx_all_t       alt_in,       // Peripheral input levels
    output gpx_byte_t      rd_data,      // Read data
    output logic           rd_valid,     // Read data valid pulse
    output gpx_vec_t       edge_ctrl,    // Edge control state
    output gpx_vec_t       irq_pending,  // Request latches
    output gpx_vec_t       irq_req       // Requests to processor
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    gpx_all_t  all_latch;  // Latches of every pin
    gpx_all_t  all_dir;    // Directions of every pin
    gpx_all_t  all_opt;    // Options of every pin
    gpx_all_t  all_ien;    // Interrupt enables of every pin
    gpx_all_t  sce_x;      // Storage engine ownership per pin
    gpx_all_t  pin_read;   // Per-pin value seen by a data read
    gpx_vec_t  evt;        // Edge events per vector
    gpx_vec_t  next_pending;
    gpx_vec_t  clr;
    gpx_byte_t ien [`GPX_NPORT];
    logic      edge_change;

    // ****************************************************************
    // Banks and edge detectors
    // ****************************************************************
    genvar p;
    generate
        for (p = 0; p < `GPX_NPORT; p++) begin : g_port
            gpx_bank_if bif ();
            logic      own;
            gpx_byte_t arm;

            // Write decode per bank
            assign bif.we_data = wr_en && wr_port == 3'(p) && wr_kind == GPX_K_DATA;
            assign bif.we_dir  = wr_en && wr_port == 3'(p) && wr_kind == GPX_K_DIR;
            assign bif.we_opt  = wr_en && wr_port == 3'(p) && wr_kind == GPX_K_OPT;
            assign bif.wdata   = wr_data;
            assign all_latch[p*8 +: 8] = bif.latch;
            assign all_dir[p*8 +: 8]   = bif.dir;
            assign all_opt[p*8 +: 8]   = bif.opt;
            assign all_ien[p*8 +: 8]   = ien[p];

            // Only the first four ports can be taken by the storage engine
            if (p < `GPX_NSCE) begin : g_sce
                assign own = sce_own[p];
            end else begin : g_nosce
                assign own = 1'b0;
            end
            assign sce_x[p*8 +: 8] = {8{own}};

            // Events only from enabled pins that are plain inputs
            assign arm = ien[p] & ~bif.dir & ~alt_en[p*8 +: 8] & ~{8{own}};

            gpx_bank u_bank (
                .clk       (clk),
                .sys_rst   (sys_rst),
                .cfg       (bif),
                .pin_in    (pin_in[p*8 +: 8]),
                .alt_en    (alt_en[p*8 +: 8]),
                .alt_val   (alt_val[p*8 +: 8]),
                .sce_own   (own),
                .sce_out   (p < `GPX_NSCE ? sce_out[(p%4)*8 +: 8] : 8'h00),
                .sce_oe    (p < `GPX_NSCE ? sce_oe[(p%4)*8 +: 8] : 8'h00),
                .pin_o     (pin_o[p*8 +: 8]),
                .pin_oe_n  (pin_oe_n[p*8 +: 8]),
                .pin_pu_en (pin_pu_en[p*8 +: 8]),
                .alt_in    (alt_in[p*8 +: 8])
            );

            gpx_edge u_edge (
                .clk     (clk),
                .sys_rst (sys_rst),
                .pin_in  (pin_in[p*8 +: 8]),
                .arm     (arm),
                .rising  (edge_ctrl[p]),
                .evt     (evt[p])
            );

            // Interrupt enable register of this port
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    ien[p] <= `GPX_RST_BYTE;
                end else if (wr_en && wr_port == 3'(p) && wr_kind == GPX_K_IEN) begin
                    ien[p] <= wr_data;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Edge control
    // ****************************************************************
    assign edge_change = edge_wr && (edge_wdata != edge_ctrl);

    // Sensitivity per vector
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            edge_ctrl <= `GPX_RST_EDGE;
        end else if (edge_wr) begin
            edge_ctrl <= edge_wdata;
        end
    end

    // ****************************************************************
    // Request latches
    // ****************************************************************
    // A write of the same setting leaves pending requests alone
    always_comb begin
        clr          = vec_fetch | {`GPX_NPORT{edge_change}};
        next_pending = (irq_pending & ~clr) | evt;
    end

    // Latch update
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_pending <= `GPX_RST_VEC;
        end else begin
            irq_pending <= next_pending;
        end
    end

    // Gated onto the processor; the latch itself stays while masked
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_req <= `GPX_RST_VEC;
        end else begin
            irq_req <= next_pending & ~{`GPX_NPORT{cpu_int_mask}};
        end
    end

    // ****************************************************************
    // Readback
    // ****************************************************************
    // Pin level for inputs and for pins owned elsewhere, latch for outputs
    assign pin_read = ((~all_dir | alt_en | sce_x) & pin_in) |
                      (all_dir & ~alt_en & ~sce_x & all_latch);

    // Registered read, one cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data  <= `GPX_RST_BYTE;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (!rd_en || rd_port >= 3'(`GPX_NPORT)) begin
                rd_data <= `GPX_RST_BYTE;
            end else begin
                case (rd_kind)
                    GPX_K_DATA: rd_data <= pin_read[rd_port*8 +: 8];
                    GPX_K_DIR:  rd_data <= all_dir[rd_port*8 +: 8];
                    GPX_K_OPT:  rd_data <= all_opt[rd_port*8 +: 8];
                    GPX_K_IEN:  rd_data <= all_ien[rd_port*8 +: 8];
                    default:    rd_data <= `GPX_RST_BYTE;
                endcase
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    generate
        for (p = 0; p < `GPX_NPORT; p++) begin : g_ast_vec
            AST_EVT_SETS: assert property (evt[p] |=> irq_pending[p])
                else $error("event did not set request");
            AST_FETCH_CLR: assert property (
                vec_fetch[p] && !evt[p] |=> !irq_pending[p])
                else $error("fetch did not clear request");
            AST_SET_WINS: assert property (
                vec_fetch[p] && evt[p] |=> irq_pending[p] ##1 (irq_pending[p] || $past(clr[p])))
                else $error("clear beat a new edge");
            // Pins with no enable can never raise the shared event
            AST_UNARMED_QUIET: assert property (all_ien[p*8 +: 8] == 8'h00 |=> !evt[p])
                else $error("disabled pins raised an event");
        end
    endgenerate

    AST_EDGE_CLR: assert property (
        edge_change && evt == 5'h00 |=> irq_pending == 5'h00)
        else $error("edge change kept pending requests");

    // Rewriting the same setting must not lose a request
    AST_SAME_EDGE_KEEP: assert property (
        edge_wr && edge_wdata == edge_ctrl && vec_fetch == 5'h00 |=> irq_pending == ($past(irq_pending) | $past(evt)))
        else $error("same edge setting cleared requests");

    AST_MASK_GATE: assert property (
        irq_req != 5'h00 |-> $past(!cpu_int_mask) && (irq_req & ~irq_pending) == 5'h00)
        else $error("request passed the processor mask");

    AST_RESET_CLEAR: assert property (
        $past(sys_rst) |-> all_latch == 40'h0 && all_dir == 40'h0 && all_opt == 40'h0)
        else $error("registers not cleared by reset");

    AST_READ_LATCH: assert property (
        rd_en && rd_kind == GPX_K_DATA && rd_port == 3'h1 && all_dir[15:8] == 8'hFF
        && alt_en[15:8] == 8'h00 && sce_x[15:8] == 8'h00 |=> rd_data == $past(all_latch[15:8]))
        else $error("output read did not return latch");

    // Port 1 is read both as inputs and as outputs by the bench
    AST_READ_INPUT: assert property (
        rd_en && rd_kind == GPX_K_DATA && rd_port == 3'h1 && all_dir[15:8] == 8'h00
        && alt_en[15:8] == 8'h00 && sce_x[15:8] == 8'h00 |=> rd_data == $past(pin_in[15:8]))
        else $error("input read did not return pin level");

    generate
        for (p = 0; p < `GPX_NALL; p++) begin : g_ast_pin
            AST_INPUT_HIZ: assert property (
                !all_dir[p] && !alt_en[p] && !sce_x[p] |=> pin_oe_n[p] && pin_pu_en[p] == $past(all_opt[p]))
                else $error("input pin driven");
            AST_OUT_DRIVE: assert property (
                all_dir[p] && !alt_en[p] && !sce_x[p]
                |=> pin_oe_n[p] == ($past(all_latch[p]) && !$past(all_opt[p])) && pin_o[p] == $past(all_latch[p]))
                else $error("output drive wrong for latch and option");
            AST_ALT_WINS: assert property (
                alt_en[p] && !sce_x[p] |=> !pin_oe_n[p] && pin_o[p] == $past(alt_val[p]))
                else $error("alternate output not forced");
            // Floating input hands the pin level to the peripheral
            AST_ALT_IN_FLOAT: assert property (!all_dir[p] && !all_opt[p] && !alt_en[p] && !sce_x[p]
                |=> alt_in[p] == $past(pin_in[p]))
                else $error("peripheral input not fed from pin");
        end
    endgenerate

    // Storage engine owns the pin outright while it holds the port
    generate
        for (p = 0; p < `GPX_NSCE * 8; p++) begin : g_ast_sce
            AST_SCE_OWNS: assert property (
                sce_x[p] |=> pin_oe_n[p] == !$past(sce_oe[p]) && pin_o[p] == $past(sce_out[p]))
                else $error("storage engine did not own the pin");
        end
    endgenerate

endmodule : gpx_port

/* File: testbench/gpx_board.sv */
// Board-side model of the pins: external drivers, pull-ups, floating wires.
// Assumes pin outputs come from gpx_port and ext signals from the bench.
`timescale 1ns/100ps

// ****************
// Pin wire model
// ****************
module gpx_board
    import gpx_pkg::*;
(
    input  wire logic     clk,       // Master clock
    input  wire gpx_all_t pin_o,     // Device output values
    input  wire gpx_all_t pin_oe_n,  // Device drive, low drives
    input  wire gpx_all_t pin_pu_en, // Device pull-ups
    input  wire gpx_all_t ext_drv,   // Board drives pin
    input  wire gpx_all_t ext_val,   // Board drive value
    output gpx_all_t      pin_in     // Resolved pin level
);
    gpx_all_t last = '0; // Level seen last cycle
    // Device drive wins; a floating wire never keeps its old level
    assign pin_in = (~pin_oe_n & pin_o) | (pin_oe_n & ext_drv & ext_val)
                  | (pin_oe_n & ~ext_drv & (pin_pu_en | ~last));
    // Remember the level so a floating pin can invert it
    always_ff @(posedge clk) begin
        last <= pin_in;
    end
endmodule : gpx_board

/* File: testbench/gpx_port_tb.sv */
// Self-checking bench for the I/O port block with a board model on the pins.
// Assumes gpx_pkg, gpx_port and gpx_board are compiled first.
`timescale 1ns/100ps

// ****************
// Bench
// ****************
module gpx_port_tb;
    import gpx_pkg::*;
    typedef struct packed {gpx_byte_t lt; gpx_byte_t dr; gpx_byte_t op;} gpx_row_t;
    logic        clk = 0, sys_rst = 1, wr_en = 0, edge_wr = 0, rd_en = 0, cpu_int_mask = 0;
    logic [2:0]  wr_port = '0, rd_port = '0;
    gpx_kind_t   wr_kind = GPX_K_DATA, rd_kind = GPX_K_DATA;
    gpx_byte_t   wr_data = '0, rd_data, r, d, l, o;
    gpx_vec_t    edge_wdata = '0, vec_fetch = '0, edge_ctrl, irq_pending, irq_req;
    gpx_all_t    pin_in, alt_en = '0, alt_val = '0, ext_val = {8'h00, 8'h00, 8'h00, 8'h96, 8'h00};
    gpx_all_t    ext_drv = '1, pin_o, pin_oe_n, pin_pu_en, alt_in;
    logic [3:0]  sce_own = '0;
    logic [31:0] sce_out = '0, sce_oe = '0;
    logic        rd_valid;
    int          failures = 0, samples_checked = 0;
    // Mixed bits in the first three rows so a pin leaning on a neighbour's bit shows up
    gpx_row_t rows[4] = '{'{8'hAA, 8'h00, 8'h0F}, '{8'h5A, 8'hFF, 8'h33},
                          '{8'hC3, 8'h0F, 8'hF0}, '{8'h00, 8'h00, 8'h00}};

    gpx_port i_gpx_port (.clk(clk), .sys_rst(sys_rst), .wr_en(wr_en), .wr_port(wr_port), .wr_kind(wr_kind),
        .wr_data(wr_data), .edge_wr(edge_wr), .edge_wdata(edge_wdata), .rd_en(rd_en), .rd_port(rd_port),
        .rd_kind(rd_kind), .vec_fetch(vec_fetch), .cpu_int_mask(cpu_int_mask), .pin_in(pin_in),
        .alt_en(alt_en), .alt_val(alt_val), .sce_own(sce_own), .sce_out(sce_out), .sce_oe(sce_oe),
        .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pin_pu_en(pin_pu_en), .alt_in(alt_in), .rd_data(rd_data),
        .rd_valid(rd_valid), .edge_ctrl(edge_ctrl), .irq_pending(irq_pending), .irq_req(irq_req));
    gpx_board i_gpx_board (.clk(clk), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pin_pu_en(pin_pu_en),
        .ext_drv(ext_drv), .ext_val(ext_val), .pin_in(pin_in));

    // Free-running master clock
    always #10 clk = ~clk;

    // Compare and count
    task chk(input string name, input gpx_byte_t exp, input gpx_byte_t got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // One write; strobe drops for an edge so back-to-back calls never collide
    task wr(input logic [2:0] p, input gpx_kind_t k, input gpx_byte_t v);
        @(posedge clk);
        wr_en <= 1; wr_port <= p; wr_kind <= k; wr_data <= v;
        @(posedge clk);
        wr_en <= 0;
    endtask : wr
    // One read, answer awaited under a bound
    task rd(input logic [2:0] p, input gpx_kind_t k, output gpx_byte_t v);
        @(posedge clk);
        rd_en <= 1; rd_port <= p; rd_kind <= k;
        @(posedge clk);
        rd_en <= 0;
        v = 8'hEE;
        for (int i = 0; i < 4; i++) begin
            #1;
            if (rd_valid === 1'b1) begin v = rd_data; break; end
            @(posedge clk);
        end
    endtask : rd
    task edge_set(input gpx_vec_t v);
        @(posedge clk);
        edge_wr <= 1; edge_wdata <= v;
        @(posedge clk);
        edge_wr <= 0;
    endtask : edge_set
    // Bounded wait on one request latch; running out counts as a mismatch
    task wait_pend(input int v, input logic e);
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            #1;
            if (irq_pending[v] === e) return;
        end
        failures++;
        $display("BAD wait_pend expected %b seen %b", e, irq_pending[v]);
    endtask : wait_pend
    task fetch(input gpx_vec_t v);
        @(posedge clk);
        vec_fetch <= v;
        @(posedge clk);
        vec_fetch <= '0;
    endtask : fetch
    task results;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results

    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 0;
        #1;
        chk("rst_oe_n", 8'hFF, pin_oe_n[7:0]);
        rd(0, GPX_K_DIR, r); chk("rst_dir", 8'h00, r);
        rd(0, GPX_K_OPT, r); chk("rst_opt", 8'h00, r);
        rd(5, GPX_K_DATA, r); chk("bad_port", 8'h00, r);
        $display("test reset done");
        // Latch first, then direction, so a pin never flashes a stale level
        foreach (rows[i]) begin
            l = rows[i].lt; d = rows[i].dr; o = rows[i].op;
            wr(1, GPX_K_DATA, l); wr(1, GPX_K_DIR, d); wr(1, GPX_K_OPT, o);
            repeat (2) @(posedge clk);
            #1;
            chk("oe_n", ~(d & (~l | o)), pin_oe_n[15:8]);
            chk("drive", d & l & o, pin_o[15:8] & ~pin_oe_n[15:8]);
            chk("pullup", ~d & o, pin_pu_en[15:8]);
            chk("alt_in", (d & l) | (~d & 8'h96), alt_in[15:8]);
            rd(1, GPX_K_DATA, r); chk("read", (d & l) | (~d & 8'h96), r);
        end
        $display("test rows done");
        // Port 2 pins 3 and 5 armed on vector 2
        wr(2, GPX_K_IEN, 8'h28);
        edge_set(5'h04);
        #1;
        chk("edge_ctrl", 8'h04, 8'(edge_ctrl));
        @(posedge clk) ext_val[19] <= 1'b1;
        wait_pend(2, 1); chk("rise", 8'h01, irq_pending[2]);
        chk("req", 8'h01, irq_req[2]);
        fetch(5'h04);
        wait_pend(2, 0); chk("fetch", 8'h00, irq_pending[2]);
        @(posedge clk) ext_val[16] <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk("unarmed", 8'h00, irq_pending[2]);
        @(posedge clk) begin cpu_int_mask <= 1; ext_val[21] <= 1'b1; end
        wait_pend(2, 1); chk("shared", 8'h01, irq_pending[2]);
        chk("masked", 8'h00, irq_req[2]);
        edge_set(5'h00);
        wait_pend(2, 0); chk("edge_clr", 8'h00, irq_pending[2]);
        @(posedge clk) begin cpu_int_mask <= 0; ext_val[19] <= 1'b0; end
        wait_pend(2, 1); chk("fall", 8'h01, irq_pending[2]);
        fetch(5'h04);
        // Fetch lands on the very cycle of a new edge event
        @(posedge clk) ext_val[21] <= 1'b0;
        repeat (2) @(posedge clk);
        fetch(5'h04);
        #1;
        chk("set_wins", 8'h01, irq_pending[2]);
        edge_set(5'h00);
        #1;
        chk("same_edge", 8'h01, irq_pending[2]);
        wr(2, GPX_K_IEN, 8'h00);
        #1;
        chk("alt_in2", 8'h01, alt_in[23:16]);
        fetch(5'h04);
        $display("test irq done");
        // Alternate output on an input pin of port 3
        @(posedge clk) begin alt_en[24] <= 1'b1; alt_val[24] <= 1'b1; end
        repeat (2) @(posedge clk);
        #1;
        chk("alt_oe", 8'h00, pin_oe_n[24]);
        chk("alt_o", 8'h01, pin_o[24]);
        rd(3, GPX_K_DATA, r); chk("alt_rd", 8'h01, r[0]);
        // Storage engine takes port 0 over
        @(posedge clk) begin sce_own <= 4'h1; sce_oe[7:0] <= 8'hFF; sce_out[7:0] <= 8'h5C; end
        repeat (2) @(posedge clk);
        #1;
        chk("sce_oe", 8'h00, pin_oe_n[7:0]);
        chk("sce_o", 8'h5C, pin_o[7:0]);
        $display("test override done");
        results();
    end
endmodule : gpx_port_tb
